/* common/icsr_pkg.sv */
/*
 * Constants for the interrupt control/status word block: register
 * indices, field positions, reset values and timing counts.
 * Assumes a 32-bit classic Wishbone bus with word-aligned registers.
 */
package icsr_pkg;
    // -------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // -------------------------------------------------------------
    localparam logic [7:0] IDX_CTRL_WORD = 8'h1D;
    localparam logic [7:0] IDX_EVT_STAT  = 8'h1E;
    localparam logic [7:0] IDX_EVT_MASK  = 8'h1F;
    localparam logic [7:0] IDX_SRC_CFG   = 8'h20;

    // -------------------------------------------------------------
    // Control word field positions
    // -------------------------------------------------------------
    localparam int CW_INT      = 15;
    localparam int CW_MASK_LSB = 13;
    localparam int CW_VEC_LSB  = 6;
    localparam int CW_BLOCK    = 5;
    localparam int CW_RSVD     = 4;
    localparam int CW_B_VIEW   = 3;
    localparam int CW_A_VIEW   = 2;
    localparam int CW_B_EDGE   = 1;
    localparam int CW_A_EDGE   = 0;

    // Source configuration fields
    localparam int SC_EN_A     = 0;
    localparam int SC_EN_B     = 1;
    localparam int SC_LVL_A    = 2;
    localparam int SC_LVL_B    = 4;

    // Event status bits
    localparam int EV_A_FALL   = 0;
    localparam int EV_B_FALL   = 1;
    localparam int EV_TAKEN    = 2;
    localparam int EV_W        = 3;

    // -------------------------------------------------------------
    // Reset values and counts
    // -------------------------------------------------------------
    localparam logic       RSVD_BIT_VAL = 1'b1;
    localparam logic [1:0] RST_HOLD_CYC = 2'd2;
    localparam logic [1:0] LVL_FIXED    = 2'd3;
    localparam logic [3:0] SRC_A        = 4'd8;
    localparam logic [3:0] SRC_B        = 4'd9;
    localparam int         N_FIXED      = 8;
endpackage

/* sim/icsr_core_model.sv */
/* Processor core model: acknowledges a pending request after a delay.
   Assumes the bench sets the delay to at least three cycles. */
`timescale 1ns/100ps
module icsr_core_model (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    input  wire logic       en_i,
    input  wire logic [3:0] dly_i,
    input  wire logic       irq_i,
    output logic            ack_o
);
    logic [3:0] cnt_r;
    // Reload after each take so a stale request line is not taken twice
    always_ff @(posedge sys_clk_i) begin
        ack_o <= 1'b0;
        if (rst_i || !en_i || irq_i !== 1'b1) begin
            cnt_r <= dly_i;
        end else if (cnt_r == 4'h0) begin
            ack_o <= 1'b1;
            cnt_r <= dly_i;
        end else begin
            cnt_r <= cnt_r - 4'h1;
        end
    end
endmodule

/* sim/icsr_sva_chk_sva.sv */
/* Checker for the control word block.
   Sees only the top module's ports; bound at the foot. */
`timescale 1ns/100ps
module icsr_sva_chk
    import icsr_pkg::*;
#(
    parameter int          ADDR_W    = 21,
    parameter logic [20:0] RESET_VEC = 21'h00_0000,
    parameter logic [6:0]  FIX_VBASE = 7'h01
) (
    input wire logic              sys_clk_i,
    input wire logic              rst_i,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_we_i,
    input wire logic [7:0]        wb_adr_i,
    input wire logic [3:0]        wb_sel_i,
    input wire logic [31:0]       wb_dat_i,
    input wire logic [31:0]       wb_dat_o,
    input wire logic              wb_ack_o,
    input wire logic              core_ack_i,
    input wire logic              core_irq_o,
    input wire logic [1:0]        core_mask_o,
    input wire logic [6:0]        core_vec_o,
    input wire logic              reset_vec_o,
    input wire logic [ADDR_W-1:0] core_vab_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    logic blk_r;
    logic rd_cw;
    // Shadow of the block bit, taken at the write's ack edge
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            blk_r <= 1'b0;
        end else if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == IDX_CTRL_WORD) begin
            blk_r <= wb_dat_i[CW_BLOCK];
        end
    end
    assign rd_cw = wb_ack_o && !wb_we_i && wb_adr_i == IDX_CTRL_WORD;
    // Reset must not hide the reset vector, so this one stays armed in reset
    a_rst_vector: assert property (disable iff (1'b0)
        rst_i |-> reset_vec_o && core_vab_o == RESET_VEC)
        else $error("reset vector missing in reset");
    a_rel_hold: assert property ($fell(rst_i) |-> reset_vec_o ##1 reset_vec_o ##1 !reset_vec_o)
        else $error("reset vector hold length wrong");
    a_irq_quiet: assert property (reset_vec_o |-> !core_irq_o)
        else $error("request while reset vector shown");
    a_vab_follow: assert property (!reset_vec_o |->
        core_vab_o == ADDR_W'({core_vec_o, 1'b0}))
        else $error("vector address not from vector number");
    a_block_all: assert property (blk_r && $past(blk_r) |-> !core_irq_o)
        else $error("request passed while blocked");
    a_fixed_lvl: assert property (core_irq_o && core_vec_o >= FIX_VBASE
        && core_vec_o < FIX_VBASE + 7'd8 |-> core_mask_o == LVL_FIXED)
        else $error("fixed source mask not top level");
    a_rsvd_read: assert property (rd_cw |->
        wb_dat_o[CW_RSVD] && wb_dat_o[31:16] == 16'h0000)
        else $error("reserved bit or upper half wrong");
    a_int_read: assert property (rd_cw |-> wb_dat_o[CW_INT] == $past(core_irq_o))
        else $error("request bit differs from request line");
    a_ack_time: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not one cycle after request");
    c_take: cover property (core_ack_i && core_irq_o);
    c_rd_cw: cover property (rd_cw);
    c_release: cover property ($fell(rst_i));
endmodule
bind icsr_top icsr_sva_chk #(.ADDR_W(ADDR_W), .RESET_VEC(RESET_VEC), .FIX_VBASE(FIX_VBASE)) u_chk (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .core_ack_i(core_ack_i),
    .core_irq_o(core_irq_o), .core_mask_o(core_mask_o), .core_vec_o(core_vec_o),
    .reset_vec_o(reset_vec_o), .core_vab_o(core_vab_o));

/* sim/tb_top.sv */
/* Self-checking bench for the control word block.
   Assumes the core model above and a one-cycle Wishbone ack. */
`timescale 1ns/100ps
module tb_top;
    import icsr_pkg::*;
    localparam logic [20:0] RVEC = 21'h0A_5A5A;
    localparam logic [6:0]  VA = 7'h10;
    localparam logic [6:0]  VB = 7'h11;
    localparam logic [6:0]  FVB = 7'h01;
    logic sys_clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic req_a_n_i = 1, req_b_n_i = 1, stop_wait_i = 0, en = 0, core_ack_i;
    logic [7:0] wb_adr_i = 0, fixed_req_i = 0;
    logic [3:0] wb_sel_i = 4'hF, dly = 4'h3;
    logic [31:0] wb_dat_i = 0, wb_dat_o, rnd = 32'h0000_357d;
    logic wb_ack_o, core_irq_o, reset_vec_o, irq_o;
    logic [1:0] core_mask_o;
    logic [6:0] core_vec_o;
    logic [20:0] core_vab_o;
    logic [63:0] exp_q[$];
    int err_total = 0, tests_run = 0;
    always #5 sys_clk_i = ~sys_clk_i;
    icsr_top #(.RESET_VEC(RVEC), .FIX_VBASE(FVB), .VEC_A(VA), .VEC_B(VB)) dut (.*);
    icsr_core_model u_core (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .en_i(en), .dly_i(dly),
        .irq_i(core_irq_o), .ack_o(core_ack_i));
    function automatic logic [31:0] xs();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd;
    endfunction
    task automatic end_of_test();
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tmo(input int n);
        if (n >= 200) begin
            err_total++;
            end_of_test();
        end
    endtask
    // Classic single cycle: hold everything until ack is sampled high
    task automatic wb_go(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 200);
        tmo(n);
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
        @(posedge sys_clk_i);
    endtask
    task automatic wb_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] c);
        exp_q.push_back({c, e & c});
        wb_go(1'b0, a, 32'h0000_0000);
    endtask
    task automatic wait_ack();
        int n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (core_ack_i !== 1'b1 && n < 200);
        tmo(n);
    endtask
    // Read data checker: oldest note against each read ack
    always @(posedge sys_clk_i) begin
        if (wb_ack_o === 1'b1 && !wb_we_i && exp_q.size() > 0) begin
            logic [63:0] e;
            e = exp_q.pop_front();
            chk("wb_dat_o", e[31:0], wb_dat_o & e[63:32]);
        end
    end
    initial begin
        logic [31:0] d;
        static logic [7:0] idx[4] = '{IDX_EVT_STAT, IDX_EVT_MASK, IDX_SRC_CFG, 8'h05};
        repeat (6) @(posedge sys_clk_i);
        chk("core_vab_o", {11'h0, RVEC}, {11'h0, core_vab_o});
        rst_i <= 0;
        @(posedge sys_clk_i);
        wb_rd(IDX_CTRL_WORD, 32'h0000_001C, '1);
        foreach (idx[k]) wb_rd(idx[k], 0, '1);
        d = xs();
        wb_go(1'b1, IDX_CTRL_WORD, d);
        wb_rd(IDX_CTRL_WORD, 32'h0000_001C | (d & 32'h0000_0023), '1);
        wb_go(1'b1, IDX_CTRL_WORD, 32'h0000_0000);
        // Every fixed source once, random take delay
        for (int i = 0; i < 8; i++) begin
            dly <= 4'(3 + xs() % 5);
            en <= 1;
            fixed_req_i <= 8'h01 << i;
            wait_ack();
            fixed_req_i <= 0;
            en <= 0;
            repeat (4) @(posedge sys_clk_i);
            d = 32'h0000_601C | (32'(FVB + 7'(i)) << 6);
            wb_rd(IDX_CTRL_WORD, d, '1);
        end
        wb_go(1'b1, IDX_SRC_CFG, 32'h0000_0017);
        // Level requests on both pins, shown on the view bits
        for (int p = 0; p < 2; p++) begin
            if (p == 0) req_a_n_i <= 0;
            else req_b_n_i <= 0;
            repeat (6) @(posedge sys_clk_i);
            wb_rd(IDX_CTRL_WORD, p ? 32'h0000_8014 : 32'h0000_8018, 32'h0000_803C);
            en <= 1;
            wait_ack();
            en <= 0;
            req_a_n_i <= 1;
            req_b_n_i <= 1;
            repeat (6) @(posedge sys_clk_i);
            wb_rd(IDX_CTRL_WORD, 32'h0000_401C | (32'(p ? VB : VA) << 6), '1);
        end
        // Both pins in edge mode: A wins the tie, B stays latched behind it
        wb_go(1'b1, IDX_CTRL_WORD, 32'h0000_0003);
        req_a_n_i <= 0;
        req_b_n_i <= 0;
        repeat (3) @(posedge sys_clk_i);
        req_a_n_i <= 1;
        req_b_n_i <= 1;
        repeat (6) @(posedge sys_clk_i);
        wb_rd(IDX_CTRL_WORD, 32'h0000_8000, 32'h0000_8000);
        for (int t = 0; t < 2; t++) begin
            en <= 1;
            wait_ack();
            en <= 0;
            repeat (4) @(posedge sys_clk_i);
            d = t ? 32'h0000_4000 | (32'(VB) << 6) : 32'h0000_C000 | (32'(VA) << 6);
            wb_rd(IDX_CTRL_WORD, d, 32'h0000_FFC0);
        end
        // Stop/Wait forces level detection despite edge select
        stop_wait_i <= 1;
        req_a_n_i <= 0;
        repeat (6) @(posedge sys_clk_i);
        wb_rd(IDX_CTRL_WORD, 32'h0000_8000, 32'h0000_8000);
        req_a_n_i <= 1;
        repeat (6) @(posedge sys_clk_i);
        wb_rd(IDX_CTRL_WORD, 0, 32'h0000_8000);
        stop_wait_i <= 0;
        wb_go(1'b1, IDX_CTRL_WORD, 32'h0000_0020);
        fixed_req_i <= 8'h80;
        repeat (4) @(posedge sys_clk_i);
        wb_rd(IDX_CTRL_WORD, 32'h0000_0020, 32'h0000_8020);
        wb_go(1'b1, IDX_CTRL_WORD, 32'h0000_0000);
        repeat (3) @(posedge sys_clk_i);
        wb_rd(IDX_CTRL_WORD, 32'h0000_8000, 32'h0000_8020);
        fixed_req_i <= 0;
        // Event interrupt: mask off, on, then clear the sticky bits
        wb_go(1'b1, IDX_EVT_MASK, 32'h0000_0000);
        repeat (2) @(posedge sys_clk_i);
        chk("irq_o", 0, {31'h0, irq_o});
        wb_go(1'b1, IDX_EVT_MASK, 32'h0000_0004);
        repeat (2) @(posedge sys_clk_i);
        chk("irq_o", 1, {31'h0, irq_o});
        wb_go(1'b1, IDX_EVT_STAT, 32'h0000_0007);
        repeat (2) @(posedge sys_clk_i);
        chk("irq_o", 0, {31'h0, irq_o});
        rst_i <= 1;
        repeat (3) @(posedge sys_clk_i);
        chk("core_vab_o", {11'h0, RVEC}, {11'h0, core_vab_o});
        rst_i <= 0;
        @(posedge sys_clk_i);
        wb_rd(IDX_EVT_MASK, 0, '1);
        // Every noted read must have been answered
        chk("exp_q", 0, exp_q.size());
        end_of_test();
    end
endmodule

/* verilog/icsr_top.sv */
/*
 * Interrupt control/status word with reset-vector presentation.
 * Holds the control word, two external request pins with level or
 * falling-edge detection, source arbitration toward the core, the
 * taken priority/vector capture, and an event interrupt.
 * Assumes: one 100 MHz clock, synchronous active-high reset, a
 * classic Wishbone master, and a core that pulses core_ack_i for one
 * cycle on entering a service routine while core_irq_o is high.
 */
// The Wishbone slave port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module icsr_top
    import icsr_pkg::*;
#(
    parameter int          ADDR_W    = 21,
    parameter logic [20:0] RESET_VEC = 21'h00_0000,
    parameter logic [6:0]  FIX_VBASE = 7'h01,
    parameter logic [6:0]  VEC_A     = 7'h10,
    parameter logic [6:0]  VEC_B     = 7'h11
) (
    input  wire logic              sys_clk_i,
    input  wire logic              rst_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic              req_a_n_i,
    input  wire logic              req_b_n_i,
    input  wire logic [N_FIXED-1:0] fixed_req_i,
    input  wire logic              stop_wait_i,
    input  wire logic              core_ack_i,
    output logic                   core_irq_o,
    output logic      [1:0]        core_mask_o,
    output logic      [6:0]        core_vec_o,
    output logic                   reset_vec_o,
    output logic      [ADDR_W-1:0] core_vab_o,
    output logic                   irq_o
);

    // -------------------------------------------------------------
    // State
    // -------------------------------------------------------------
    typedef struct packed {
        logic             ack;
        logic [15:0]      dat;
        logic             a_s1;
        logic             a_s2;
        logic             a_prev;
        logic             b_s1;
        logic             b_s2;
        logic             b_prev;
        logic             lat_a;
        logic             lat_b;
        logic             blk;
        logic             edge_a;
        logic             edge_b;
        logic [1:0]       en;
        logic [1:0]       lvl_a;
        logic [1:0]       lvl_b;
        logic [1:0]       tk_mask;
        logic [6:0]       tk_vec;
        logic             req;
        logic [1:0]       pr_mask;
        logic [6:0]       pr_vec;
        logic [3:0]       pr_src;
        logic [1:0]       rst_cnt;
        logic [EV_W-1:0]  stat;
        logic [EV_W-1:0]  msk;
        logic             irq;
    } icsr_state_t;

    icsr_state_t st_r;
    icsr_state_t st_nxt;

    logic [15:0]     ctrl_word;
    logic            acc;
    logic            wr;
    logic            a_fall;
    logic            b_fall;
    logic            pend_a;
    logic            pend_b;
    logic            taken;
    logic            cand;
    logic [1:0]      c_lvl;
    logic [6:0]      c_vec;
    logic [3:0]      c_src;
    logic [EV_W-1:0] ev;
    logic [31:0]     rd;

    // -------------------------------------------------------------
    // Control word image
    // -------------------------------------------------------------
    always_comb begin
        ctrl_word              = '0;
        ctrl_word[CW_INT]      = st_r.req;
        ctrl_word[CW_MASK_LSB+:2] = st_r.tk_mask;
        ctrl_word[CW_VEC_LSB+:7]  = st_r.tk_vec;
        ctrl_word[CW_BLOCK]    = st_r.blk;
        ctrl_word[CW_RSVD]     = RSVD_BIT_VAL;
        ctrl_word[CW_B_VIEW]   = st_r.b_s2;
        ctrl_word[CW_A_VIEW]   = st_r.a_s2;
        ctrl_word[CW_B_EDGE]   = st_r.edge_b;
        ctrl_word[CW_A_EDGE]   = st_r.edge_a;
    end

    // -------------------------------------------------------------
    // Pin detection
    // -------------------------------------------------------------
    // Stop/Wait forces level mode since no edge can be seen clockless
    always_comb begin
        a_fall = st_r.a_prev & ~st_r.a_s2;
        b_fall = st_r.b_prev & ~st_r.b_s2;
        if (st_r.edge_a && !stop_wait_i) begin
            pend_a = st_r.lat_a;
        end else begin
            pend_a = ~st_r.a_s2;
        end
        if (st_r.edge_b && !stop_wait_i) begin
            pend_b = st_r.lat_b;
        end else begin
            pend_b = ~st_r.b_s2;
        end
        pend_a = pend_a & st_r.en[SC_EN_A];
        pend_b = pend_b & st_r.en[SC_EN_B];
    end

    // -------------------------------------------------------------
    // Arbitration: fixed sources first, lowest index wins
    // -------------------------------------------------------------
    always_comb begin
        cand  = 1'b0;
        c_lvl = '0;
        c_vec = '0;
        c_src = '0;
        if (pend_b) begin
            cand  = 1'b1;
            c_lvl = st_r.lvl_b;
            c_vec = VEC_B;
            c_src = SRC_B;
        end
        if (pend_a && (!pend_b || st_r.lvl_a >= st_r.lvl_b)) begin
            cand  = 1'b1;
            c_lvl = st_r.lvl_a;
            c_vec = VEC_A;
            c_src = SRC_A;
        end
        for (int i = N_FIXED - 1; i >= 0; i--) begin
            if (fixed_req_i[i]) begin
                cand  = 1'b1;
                c_lvl = LVL_FIXED;
                c_vec = FIX_VBASE + 7'(i);
                c_src = 4'(i);
            end
        end
    end

    // -------------------------------------------------------------
    // Bus decode and read mux
    // -------------------------------------------------------------
    // Write lands on the edge where the master sees ack high
    assign acc   = wb_cyc_i & wb_stb_i;
    assign wr    = acc & wb_we_i & st_r.ack;
    assign taken = core_ack_i & st_r.req;

    always_comb begin
        rd = '0;
        unique case (wb_adr_i[7:0])
            IDX_CTRL_WORD: rd[15:0] = ctrl_word;
            IDX_EVT_STAT:  rd[EV_W-1:0] = st_r.stat;
            IDX_EVT_MASK:  rd[EV_W-1:0] = st_r.msk;
            IDX_SRC_CFG:   rd[5:0] = {st_r.lvl_b, st_r.lvl_a, st_r.en};
            default:       rd = '0;                        // Unmapped reads zero
        endcase
    end

    // -------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------
    always_comb begin
        st_nxt        = st_r;
        st_nxt.ack    = acc & ~st_r.ack;
        st_nxt.dat    = rd[15:0];
        st_nxt.a_s1   = req_a_n_i;
        st_nxt.a_s2   = st_r.a_s1;
        st_nxt.a_prev = st_r.a_s2;
        st_nxt.b_s1   = req_b_n_i;
        st_nxt.b_s2   = st_r.b_s1;
        st_nxt.b_prev = st_r.b_s2;
        ev            = '0;
        ev[EV_A_FALL] = a_fall;
        ev[EV_B_FALL] = b_fall;
        ev[EV_TAKEN]  = taken;

        // Register writes, low byte lane only; the high byte lane is not written
        if (wr && wb_sel_i[0]) begin
            unique case (wb_adr_i[7:0])
                IDX_CTRL_WORD: begin
                    st_nxt.blk    = wb_dat_i[CW_BLOCK];
                    st_nxt.edge_b = wb_dat_i[CW_B_EDGE];
                    st_nxt.edge_a = wb_dat_i[CW_A_EDGE];
                end
                IDX_EVT_STAT: st_nxt.stat = st_r.stat & ~wb_dat_i[EV_W-1:0];
                IDX_EVT_MASK: st_nxt.msk = wb_dat_i[EV_W-1:0];
                IDX_SRC_CFG: begin
                    st_nxt.en    = wb_dat_i[SC_EN_A+:2];
                    st_nxt.lvl_a = wb_dat_i[SC_LVL_A+:2];
                    st_nxt.lvl_b = wb_dat_i[SC_LVL_B+:2];
                end
                default: st_nxt.msk = st_r.msk;
            endcase
        end
        // Set wins over a clear in the same cycle
        st_nxt.stat = st_nxt.stat | ev;

        // Edge latches: set wins over the take that clears them
        if (taken && st_r.pr_src == SRC_A) begin
            st_nxt.lat_a = 1'b0;
        end
        if (taken && st_r.pr_src == SRC_B) begin
            st_nxt.lat_b = 1'b0;
        end
        if (a_fall && st_r.edge_a && !stop_wait_i) begin
            st_nxt.lat_a = 1'b1;
        end
        if (b_fall && st_r.edge_b && !stop_wait_i) begin
            st_nxt.lat_b = 1'b1;
        end

        // Capture on entry only; nesting may overwrite before a read
        if (taken) begin
            st_nxt.tk_mask = st_r.pr_mask;
            st_nxt.tk_vec  = st_r.pr_vec;
        end

        // Present to the core; held off while the reset vector shows
        st_nxt.req    = cand & ~st_r.blk & (st_r.rst_cnt == '0);
        st_nxt.pr_vec = c_vec;
        st_nxt.pr_src = c_src;
        // New mask lets only strictly higher levels nest
        if (c_lvl == LVL_FIXED) begin
            st_nxt.pr_mask = LVL_FIXED;
        end else begin
            st_nxt.pr_mask = c_lvl + 2'd1;
        end

        // Reset vector hold counts down after release
        if (st_r.rst_cnt != '0) begin
            st_nxt.rst_cnt = st_r.rst_cnt - 2'd1;
        end
        st_nxt.irq = |(st_nxt.stat & st_nxt.msk);
    end

    // -------------------------------------------------------------
    // State register
    // -------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st_r         <= '0;
            st_r.a_s1    <= 1'b1;
            st_r.a_s2    <= 1'b1;
            st_r.a_prev  <= 1'b1;
            st_r.b_s1    <= 1'b1;
            st_r.b_s2    <= 1'b1;
            st_r.b_prev  <= 1'b1;
            st_r.rst_cnt <= RST_HOLD_CYC;
        end else begin
            st_r <= st_nxt;
        end
    end

    // -------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------
    assign wb_ack_o    = st_r.ack;
    assign wb_dat_o    = {16'h0000, st_r.dat};
    assign core_irq_o  = st_r.req;
    assign core_mask_o = st_r.pr_mask;
    assign core_vec_o  = st_r.pr_vec;
    assign irq_o       = st_r.irq;
    // Reset vector shows at once in reset and for two edges after it
    assign reset_vec_o = rst_i | (st_r.rst_cnt != '0);
    assign core_vab_o  = reset_vec_o ? RESET_VEC[ADDR_W-1:0]
                                     : ADDR_W'({st_r.pr_vec, 1'b0});

endmodule
